/* design/bbwi_block_map.sv */
// Top-boot block map decoder.
`timescale 1ns/1ps
`include "bbwi_params.svh"
module bbwi_block_map
    import bbwi_pkg::*;
#(
    parameter int ADDR_W = `BBWI_ADDR_W
)
(
    // Address in
    input wire logic [ADDR_W-1:0] addr,
    // Decode out
    output logic is_param_block,
    output logic [7:0] block_index
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb
    begin
        is_param_block = (addr >= `BBWI_PARAM_BASE);
        if (is_param_block)
        begin
            block_index = `BBWI_PARAM_IDX_BASE + {5'h00, addr[14:12]};
        end
        else
        begin
            block_index = {1'b0, addr[21:15]};
        end
    end
endmodule

/* design/bbwi_burst.sv */
// Burst sequencer with first-boundary wait insertion.
`timescale 1ns/1ps
`include "bbwi_params.svh"
module bbwi_burst
    import bbwi_pkg::*;
#(
    parameter int ADDR_W = `BBWI_ADDR_W
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Burst control from host
    input wire logic burst_start,
    input wire logic burst_stop,
    input wire logic [ADDR_W-1:0] start_addr,
    input wire logic [2:0] initial_latency_code_bits,
    // Data path
    output logic [ADDR_W-1:0] burst_addr,
    output logic data_valid,
    output logic wait_active,
    output logic [2:0] extra_cycles,
    // Block map
    output logic is_param_block,
    output logic [7:0] block_index
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bbwi_state_type state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [2:0] extra_r, extra_nxt;
    logic crossed_r, crossed_nxt;
    logic valid_r, valid_nxt;
    logic [4:0] diff;
    logic [2:0] lat_eff;
    logic at_boundary;

    // Codes above the top setting are clamped so the count stays in range.
    assign lat_eff = (initial_latency_code_bits > `BBWI_LAT_MAX) ? `BBWI_LAT_MAX
                     : initial_latency_code_bits;
    // Residue plus code minus four, as a 5-bit signed-style difference.
    assign diff = {2'b00, start_addr[2:0]} + {2'b00, lat_eff} - 5'h04;
    // Boundary at low nibble all ones, and at address zero.
    assign at_boundary = (addr_r[3:0] == `BBWI_BND_MASK) || (addr_r == '0);

    always_comb
    begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        extra_nxt = extra_r;
        crossed_nxt = crossed_r;
        valid_nxt = 1'b0;
        case (state_r)
            BBWI_IDLE:
            begin
                if (burst_start)
                begin
                    addr_nxt = start_addr;
                    extra_nxt = diff[4] ? 3'h0 : diff[2:0];
                    cnt_nxt = `BBWI_LAT_BASE + {1'b0, lat_eff} - 4'h2;
                    crossed_nxt = 1'b0;
                    state_nxt = BBWI_LAT;
                end
            end
            BBWI_LAT:
            begin
                if (cnt_r == 4'h0)
                begin
                    valid_nxt = 1'b1;
                    state_nxt = BBWI_RUN;
                end
                else
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            BBWI_RUN:
            begin
                valid_nxt = 1'b1;
                // First crossing waits; a start word that sits on a boundary counts as the crossing.
                if (at_boundary && !crossed_r && valid_r && extra_r != 3'h0)
                begin
                    crossed_nxt = 1'b1;
                    cnt_nxt = {1'b0, extra_r} - 4'h1;
                    valid_nxt = 1'b0;
                    state_nxt = BBWI_WAIT;
                end
                else
                begin
                    if (at_boundary && valid_r)
                    begin
                        crossed_nxt = 1'b1;
                    end
                    addr_nxt = addr_r + 1'b1;
                end
            end
            BBWI_WAIT:
            begin
                valid_nxt = 1'b0;
                if (cnt_r == 4'h0)
                begin
                    addr_nxt = addr_r + 1'b1;
                    valid_nxt = 1'b1;
                    state_nxt = BBWI_RUN;
                end
                else
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default:
            begin
                state_nxt = BBWI_IDLE;
            end
        endcase
        if (burst_stop)
        begin
            state_nxt = BBWI_IDLE;
            valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r <= BBWI_IDLE;
            addr_r <= '0;
            cnt_r <= 4'h0;
            extra_r <= 3'h0;
            crossed_r <= 1'b0;
            valid_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
            extra_r <= extra_nxt;
            crossed_r <= crossed_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign burst_addr = addr_r;
    assign data_valid = valid_r;
    assign wait_active = (state_r == BBWI_WAIT);
    assign extra_cycles = extra_r;

    bbwi_block_map #(.ADDR_W(ADDR_W)) u_map
    (
        .addr(addr_r),
        .is_param_block(is_param_block),
        .block_index(block_index)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wait_holds_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_WAIT && state_nxt == BBWI_WAIT) |=> $stable(addr_r))
        else $error("Address moved during wait.");
    wait_no_data_a: assert property (@(posedge clk_sys) disable iff (srst)
        wait_active |-> !data_valid)
        else $error("Data valid during wait.");
    wait_once_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_RUN && crossed_r) |=> state_r != BBWI_WAIT)
        else $error("Second boundary waited.");
    extra_range_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_IDLE && burst_start && !burst_stop && start_addr[2:0] == 3'h7
         && initial_latency_code_bits == 3'h4) |=> extra_r == 3'h7)
        else $error("Extra count wrong for top case.");
    extra_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_IDLE && burst_start && start_addr[2:0] == 3'h0) |=> extra_r == 3'h0)
        else $error("Group zero needs no extra cycles.");
    param_decode_a: assert property (@(posedge clk_sys) disable iff (srst)
        (addr_r[21:12] == 10'h3F8) |-> (is_param_block && block_index == 8'h7F))
        else $error("Lowest parameter block misdecoded.");
    main_decode_a: assert property (@(posedge clk_sys) disable iff (srst)
        (addr_r[21:15] == 7'h7E) |-> (!is_param_block && block_index == 8'h7E))
        else $error("Highest main block misdecoded.");
    boundary_set_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_RUN && valid_r && addr_r[3:0] == 4'hF && !burst_stop) |=> crossed_r)
        else $error("Boundary not recorded.");
    zero_boundary_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_RUN && valid_r && addr_r == '0 && !burst_stop) |=> crossed_r)
        else $error("Address zero not recorded as a boundary.");
    start_capture_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_IDLE && burst_start && !burst_stop)
        |=> (state_r == BBWI_LAT && burst_addr == $past(start_addr)))
        else $error("Start address not captured.");
    lat_first_valid_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_LAT && cnt_r == 4'h0 && !burst_stop) |=> data_valid)
        else $error("First word missing after latency.");
    wait_resume_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_WAIT && cnt_r == 4'h0 && !burst_stop)
        |=> (data_valid && burst_addr == ADDR_W'($past(addr_r) + 1'b1)))
        else $error("Burst did not resume after wait.");
    run_advance_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_RUN && crossed_r && !burst_stop)
        |=> (data_valid && burst_addr == ADDR_W'($past(addr_r) + 1'b1)))
        else $error("Later boundary stalled the burst.");

    // ------------------------------------------------------------
    // Wait length monitor
    // ------------------------------------------------------------
    // Counts inserted cycles on its own, so a wrong reload of the
    // wait counter shows up as a length that differs from the count.
    logic [3:0] wait_seen_r, wait_seen_nxt;

    always_comb
    begin
        wait_seen_nxt = 4'h0;
        if (state_r == BBWI_WAIT)
        begin
            wait_seen_nxt = wait_seen_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wait_seen_r <= 4'h0;
        end
        else
        begin
            wait_seen_r <= wait_seen_nxt;
        end
    end

    wait_length_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == BBWI_RUN && wait_seen_r != 4'h0) |-> wait_seen_r == {1'b0, extra_r})
        else $error("Wait length differs from extra count.");
endmodule

/* design/bbwi_params.svh */
// Constants for the burst boundary wait insertion block.
`ifndef BBWI_PARAMS_SVH
`define BBWI_PARAMS_SVH
`define BBWI_ADDR_W 22
`define BBWI_LAT_W 3
`define BBWI_LAT_MAX 3'h4
`define BBWI_LAT_BASE 4'h4
`define BBWI_BND_MASK 4'hF
`define BBWI_PARAM_BASE 22'h3F_8000
`define BBWI_PARAM_SHIFT 12
`define BBWI_MAIN_SHIFT 15
`define BBWI_MAIN_TOP 7'h7E
`define BBWI_PARAM_IDX_BASE 8'h7F
`endif

/* design/bbwi_pkg.sv */
// Types for the burst boundary wait insertion block.
package bbwi_pkg;
    typedef enum logic [1:0] {BBWI_IDLE, BBWI_LAT, BBWI_RUN, BBWI_WAIT} bbwi_state_type;
endpackage

/* verification/bbwi_host_model.sv */
// Host controller model that launches and ends bursts.
`timescale 1ns/1ps
module bbwi_host_model
(
    // Clock
    input wire logic clk_sys,
    // Burst control
    output logic burst_start,
    output logic burst_stop,
    output logic [21:0] start_addr,
    output logic [2:0] lat_code
);
    initial
    begin
        burst_start = 1'b0;
        burst_stop = 1'b1;
        start_addr = 22'h00_0000;
        lat_code = 3'h0;
    end
    // The address is scrambled once taken, so a stale value cannot pass unseen.
    task automatic go(input logic [21:0] a, input logic [2:0] c);
        @(posedge clk_sys);
        burst_stop <= 1'b0;
        burst_start <= 1'b1;
        start_addr <= a;
        lat_code <= c;
        @(posedge clk_sys);
        burst_start <= 1'b0;
        start_addr <= ~a;
    endtask
    task automatic stop();
        @(posedge clk_sys);
        burst_stop <= 1'b1;
    endtask
endmodule

/* verification/test_burst_boundary_wait_insert.sv */
// Self-checking bench for the burst sequencer.
`timescale 1ns/1ps
module test_burst_boundary_wait_insert;
    typedef struct {logic [21:0] a; logic [2:0] c; logic [2:0] x; logic p; logic [7:0] k;}
        bbwi_row_type;
    logic clk_sys;
    logic srst;
    logic burst_start, burst_stop, data_valid, wait_active, is_param_block;
    logic [21:0] start_addr, burst_addr, prev;
    logic [2:0] lat_code, extra_cycles;
    logic [7:0] block_index;
    int n_mismatch = 0;
    int compares = 0;
    int n, waits, clash;
    bbwi_row_type rows [8] = '{
        '{22'h3F_8003, 3'h4, 3'h3, 1'b1, 8'h7F},
        '{22'h3F_F007, 3'h0, 3'h3, 1'b1, 8'h86},
        '{22'h3F_7FF8, 3'h3, 3'h0, 1'b0, 8'h7E},
        '{22'h00_0005, 3'h1, 3'h2, 1'b0, 8'h00},
        '{22'h12_3456, 3'h2, 3'h4, 1'b0, 8'h24},
        '{22'h3F_8FFF, 3'h7, 3'h7, 1'b1, 8'h7F},
        '{22'h3F_9000, 3'h4, 3'h0, 1'b1, 8'h80},
        '{22'h00_0000, 3'h2, 3'h0, 1'b0, 8'h00}};

    bbwi_host_model host (.clk_sys(clk_sys), .burst_start(burst_start),
        .burst_stop(burst_stop), .start_addr(start_addr), .lat_code(lat_code));

    bbwi_burst uut (.clk_sys(clk_sys), .srst(srst), .burst_start(burst_start),
        .burst_stop(burst_stop), .start_addr(start_addr),
        .initial_latency_code_bits(lat_code), .burst_addr(burst_addr),
        .data_valid(data_valid), .wait_active(wait_active), .extra_cycles(extra_cycles),
        .is_param_block(is_param_block), .block_index(block_index));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Bursts take about fifty cycles each, so this leaves a wide margin.
    initial
    begin
        #(40 * 4000);
        n_mismatch++;
        close_out();
    end

    initial
    begin
        srst = 1'b1;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        foreach (rows[i])
        begin
            host.go(rows[i].a, rows[i].c);
            n = 0;
            do
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            while (data_valid !== 1'b1 && n < 20);
            // The start edge is the first clock of the latency count.
            check(24'(n + 1), 24'(4 + ((rows[i].c > 3'h4) ? 4 : rows[i].c)));
            check(24'(burst_addr), 24'(rows[i].a));
            check(24'(extra_cycles), 24'(rows[i].x));
            check(24'(is_param_block), 24'(rows[i].p));
            check(24'(block_index), 24'(rows[i].k));
            waits = 0;
            clash = 0;
            prev = burst_addr;
            repeat (40)
            begin
                @(posedge clk_sys);
                #1;
                if (wait_active === 1'b1)
                begin
                    waits++;
                    if (data_valid !== 1'b0 || burst_addr !== prev)
                        clash++;
                end
                prev = burst_addr;
            end
            check(24'(waits), 24'(rows[i].x));
            check(24'(clash), 24'h00_0000);
            host.stop();
            @(posedge clk_sys);
            $display("Row %0d done", i);
        end
        // A reset in mid-burst must clear the outputs on the clock edge that samples it.
        host.go(22'h00_0007, 3'h4);
        repeat (18) @(posedge clk_sys);
        #1;
        check(24'(wait_active), 24'h00_0001);
        @(posedge clk_sys);
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        check(24'(data_valid), 24'h00_0000);
        check(24'(extra_cycles), 24'h00_0000);
        check(24'(wait_active), 24'h00_0000);
        check(24'(burst_addr), 24'h00_0000);
        host.stop();
        $display("Mid-burst reset done");
        close_out();
    end
endmodule
